//--- design/efb_pkg.sv
// constants, register map and parity helpers for the embedded fifo block
// assumes one 50 MHz mclk and an AHB-Lite slave port for the registers
`default_nettype none
package efb_pkg;
  localparam int DATA_W = 9; // stored word incl parity bit
  localparam int PAY_W = 8; // payload bits below the parity bit
  localparam int LEVEL_W = 8; // threshold input width
  localparam int FINE_MAX = 256; // deepest fifo with exact level steps
  // pin sample vector layout
  localparam int PIN_W = 16;
  localparam int P_WDATA = 0; // lsb of nine write data bits
  localparam int P_WCLK = 9;
  localparam int P_RCLK = 10;
  localparam int P_WSEL = 11;
  localparam int P_WSTB = 12;
  localparam int P_RSEL = 13;
  localparam int P_RSTB = 14;
  localparam int P_RST = 15;
  localparam logic [PIN_W-1:0] PIN_RST_VAL = 16'hf800; // active-low pins idle high
  // register byte offsets
  localparam int DEC_W = 8; // decoded address bits
  localparam logic [DEC_W-1:0] REG_CTRL = 8'h00;
  localparam logic [DEC_W-1:0] REG_STATUS = 8'h04;
  localparam logic [DEC_W-1:0] REG_INT_STAT = 8'h08;
  localparam logic [DEC_W-1:0] REG_INT_CLR = 8'h0c;
  localparam logic [DEC_W-1:0] REG_INT_EN = 8'h10;
  // control fields
  localparam int CTL_DSEL = 0; // depth select lsb
  localparam int CTL_ODD = 4; // parity polarity
  localparam int CTL_GEN = 5; // parity generate enable
  localparam int CTL_LVL = 8; // level lsb
  localparam logic [31:0] CTRL_RST = 32'h0000_0007; // deepest when ADDR_W is 8 or less, even, no gen
  // status fields
  localparam int ST_FULL = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_EQ = 2;
  localparam int ST_GEQ = 3;
  localparam int ST_WPE = 4;
  localparam int ST_RPE = 5;
  localparam int ST_CNT = 16; // occupancy lsb
  // interrupt bits
  localparam int INT_W = 4;
  localparam int I_WPE = 0;
  localparam int I_RPE = 1;
  localparam int I_OVF = 2; // write refused while full
  localparam int I_UNF = 3; // read refused while empty
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ninth bit that gives the selected parity over nine bits
  function automatic logic parityBit(input logic [PAY_W-1:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction

  // true when a nine-bit word holds the selected parity
  function automatic logic parityOk(input logic [DATA_W-1:0] w, input logic odd);
    return (^w) == odd;
  endfunction
endpackage
`default_nettype wire

//--- design/efb_pin_sync.sv
// two-stage synchroniser for a vector of asynchronous pins
// assumes pins are sampled on mclk; each bit settles independently
`default_nettype none
module efb_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q; // first stage, read only by the second

  // two flops in series, nothing else looks at meta_q
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // efb_pin_sync
`default_nettype wire

//--- design/efb_store.sv
// flip-flop word storage with one write and one registered read port
// assumes caller keeps addresses in range; contents survive reset
`default_nettype none
module efb_store
  import efb_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrWord,
  input wire logic rdEn,
  input wire logic rdClr,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdWord
);
  logic [DATA_W-1:0] mem [2**ADDR_W]; // never reset, data kept

  // write port
  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrWord;
    end
  end

  // read register, zeroed by either reset
  always_ff @(posedge mclk) begin
    if (sys_rst || rdClr) begin
      rdWord <= '0;
    end else if (rdEn) begin
      rdWord <= mem[rdAddr];
    end
  end
endmodule // efb_store
`default_nettype wire

//--- design/efb_fifo_top.sv
// embedded fifo block: pin side fifo, flags, parity, AHB-Lite registers
// assumes pins are asynchronous to mclk and toggle well below mclk/4
`default_nettype none
module efb_fifo_top
  import efb_pkg::*;
#(
  parameter int ADDR_W = 8, // storage address bits
  parameter int DSEL_W = 3 // depth select width
) (
  input wire logic mclk,
  input wire logic sys_rst,
  // fifo pins
  input wire logic wr_clk,
  input wire logic wr_sel_n,
  input wire logic wr_strobe_n,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic rd_clk,
  input wire logic rd_sel_n,
  input wire logic rd_strobe_n,
  input wire logic fifo_rst_n,
  output logic [DATA_W-1:0] rd_data,
  output logic full,
  output logic empty,
  output logic at_thresh,
  output logic at_or_above_thresh,
  output logic rd_parity_err,
  output logic wr_parity_err,
  output logic irq,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);
  localparam int CNT_W = ADDR_W + 1; // occupancy incl full count

  // pin sampling
  logic [PIN_W-1:0] pinRaw; // raw pin vector
  logic [PIN_W-1:0] pinS; // synchronised pins
  logic wrClkP_q; // previous write clock sample
  logic rdClkP_q; // previous read clock sample
  logic wrRise; // write clock rising
  logic rdRise; // read clock rising
  logic rdFall; // read clock falling
  logic ptrClr; // pointer clear from the fifo_rst_n pin only
  logic [DATA_W-1:0] wrDataS; // synchronised write data

  // configuration
  logic [31:0] ctrl_q; // control register
  logic [DSEL_W-1:0] depthSel; // depth select field
  logic parity_odd_sel; // odd parity when high
  logic parity_gen_en; // generate ninth bit
  logic [LEVEL_W-1:0] level; // threshold level
  logic [CNT_W-1:0] depthW; // selected capacity
  logic coarse; // capacity above exact level range

  // fifo state
  logic [ADDR_W-1:0] wrPtr_q; // next write slot
  logic [ADDR_W-1:0] rdPtr_q; // next read slot
  logic [CNT_W-1:0] count_q; // stored words
  logic empty_q; // empty flag
  logic eq_q; // equal threshold flag
  logic geq_q; // at or above threshold flag
  logic wpe_q; // write parity error
  logic rpe_q; // read parity error
  logic rdDone_q; // read data landed last cycle
  logic wrReq; // write request on rising edge
  logic rdReq; // read request on rising edge
  logic wrDo; // accepted write
  logic rdDo; // accepted read
  logic [DATA_W-1:0] wrWord; // word as stored
  logic [DATA_W-1:0] rdWord; // word from storage
  logic eqD; // next equal flag
  logic geqD; // next at or above flag

  // interrupts and bus
  logic [INT_W-1:0] intStat_q; // sticky events
  logic [INT_W-1:0] intEn_q; // event enables
  logic [INT_W-1:0] intEv; // this cycle's events
  logic [INT_W-1:0] intClr; // clear bits written this cycle
  logic dpWr_q; // write data phase pending
  logic [DEC_W-1:0] dpAddr_q; // data phase address
  logic [31:0] rdMux; // read data selected by address
  logic addrPhase; // accepted address phase

  // capacity for a select code, clamped to storage
  function automatic logic [CNT_W-1:0] depthWords(input logic [DSEL_W-1:0] sel);
    int unsigned lg;
    lg = int'(sel) + 1;
    if (lg > ADDR_W) begin
      lg = ADDR_W;
    end
    return CNT_W'(1) << lg;
  endfunction

  // pointer step with wrap at the selected capacity
  function automatic logic [ADDR_W-1:0] nextPtr(input logic [ADDR_W-1:0] p,
                                                input logic [CNT_W-1:0] d);
    return (CNT_W'(p) == d - CNT_W'(1)) ? '0 : p + ADDR_W'(1);
  endfunction

  assign pinRaw = {fifo_rst_n, rd_strobe_n, rd_sel_n, wr_strobe_n, wr_sel_n,
                   rd_clk, wr_clk, wr_data};

  // every pin passes two flops before use
  efb_pin_sync #(
    .W(PIN_W),
    .RST_VAL(PIN_RST_VAL)
  ) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din(pinRaw),
    .dout(pinS)
  );

  // clock edge history for the two pin clocks
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wrClkP_q <= 1'b0;
      rdClkP_q <= 1'b0;
    end else begin
      wrClkP_q <= pinS[P_WCLK];
      rdClkP_q <= pinS[P_RCLK];
    end
  end

  // edges of each side's own clock drive that side only
  assign wrRise = pinS[P_WCLK] & ~wrClkP_q;
  assign rdRise = pinS[P_RCLK] & ~rdClkP_q;
  assign rdFall = ~pinS[P_RCLK] & rdClkP_q;
  assign ptrClr = ~pinS[P_RST];
  assign wrDataS = pinS[P_WDATA +: DATA_W];
  // control fields
  assign depthSel = ctrl_q[CTL_DSEL +: DSEL_W];
  assign parity_odd_sel = ctrl_q[CTL_ODD];
  assign parity_gen_en = ctrl_q[CTL_GEN];
  assign level = ctrl_q[CTL_LVL +: LEVEL_W];
  assign depthW = depthWords(depthSel);
  assign coarse = depthW > CNT_W'(FINE_MAX);
  // requests need select and strobe both low at the rising edge
  assign wrReq = wrRise & ~pinS[P_WSEL] & ~pinS[P_WSTB];
  assign rdReq = rdRise & ~pinS[P_RSEL] & ~pinS[P_RSTB];
  assign wrDo = wrReq & ~full & ~ptrClr;
  assign rdDo = rdReq & ~empty_q & ~ptrClr;
  assign full = count_q >= depthW;
  // ninth bit from the generator or from the pin
  assign wrWord = parity_gen_en ? {parityBit(wrDataS[PAY_W-1:0], parity_odd_sel), wrDataS[PAY_W-1:0]}
                         : wrDataS;

  efb_store #(
    .ADDR_W(ADDR_W)
  ) u_store (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wrEn(wrDo),
    .wrAddr(wrPtr_q),
    .wrWord(wrWord),
    .rdEn(rdDo),
    .rdClr(ptrClr),
    .rdAddr(rdPtr_q),
    .rdWord(rdWord)
  );
  assign rd_data = rdWord;
  // pointers and occupancy
  always_ff @(posedge mclk) begin
    if (sys_rst || ptrClr) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (wrDo) begin
        wrPtr_q <= nextPtr(wrPtr_q, depthW);
      end
      if (rdDo) begin
        rdPtr_q <= nextPtr(rdPtr_q, depthW);
      end
      count_q <= count_q + CNT_W'(wrDo) - CNT_W'(rdDo);
    end
  end

  // empty flag moves only on the read clock falling edge or a reset
  always_ff @(posedge mclk) begin
    if (sys_rst || ptrClr) begin
      empty_q <= 1'b1;
    end else if (rdFall) begin
      empty_q <= count_q == '0;
    end
  end
  assign empty = empty_q;

  // threshold compare, coarse mode matches one above twice the level
  always_comb begin
    if (coarse) begin
      eqD = count_q == CNT_W'({level, 1'b0}) + CNT_W'(1);
      geqD = count_q >= CNT_W'({level, 1'b0}) + CNT_W'(1);
    end else begin
      eqD = count_q == CNT_W'(level);
      geqD = count_q >= CNT_W'(level);
    end
  end

  // threshold flags registered
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      eq_q <= 1'b0;
      geq_q <= 1'b0;
    end else begin
      eq_q <= eqD;
      geq_q <= geqD;
    end
  end
  assign at_thresh = eq_q;
  assign at_or_above_thresh = geq_q;

  // write parity check on each accepted write of pin parity
  always_ff @(posedge mclk) begin
    if (sys_rst || ptrClr) begin
      wpe_q <= 1'b0;
    end else if (wrDo) begin
      wpe_q <= ~parity_gen_en & ~parityOk(wrDataS, parity_odd_sel);
    end
  end
  assign wr_parity_err = wpe_q;

  // read parity check one cycle after the word lands
  always_ff @(posedge mclk) begin
    if (sys_rst || ptrClr) begin
      rdDone_q <= 1'b0;
      rpe_q <= 1'b0;
    end else begin
      rdDone_q <= rdDo;
      if (rdDone_q) begin
        rpe_q <= ~parityOk(rdWord, parity_odd_sel);
      end
    end
  end
  assign rd_parity_err = rpe_q;

  // event sources for the interrupt status
  assign intEv[I_WPE] = wrDo & ~parity_gen_en & ~parityOk(wrDataS, parity_odd_sel);
  assign intEv[I_RPE] = rdDone_q & ~parityOk(rdWord, parity_odd_sel);
  assign intEv[I_OVF] = wrReq & full; // refused write
  assign intEv[I_UNF] = rdReq & empty_q; // refused read
  // bus: zero wait, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign intClr = (dpWr_q && dpAddr_q == REG_INT_CLR) ? hwdata[INT_W-1:0] : '0;

  // address phase capture
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dpWr_q <= 1'b0;
      dpAddr_q <= '0;
    end else begin
      dpWr_q <= addrPhase & hwrite;
      dpAddr_q <= haddr[DEC_W-1:0];
    end
  end

  // read mux, unmapped reads give zero
  always_comb begin
    rdMux = '0;
    unique case (haddr[DEC_W-1:0])
      REG_CTRL: rdMux = ctrl_q;
      REG_STATUS: begin
        rdMux[ST_FULL] = full;
        rdMux[ST_EMPTY] = empty_q;
        rdMux[ST_EQ] = eq_q;
        rdMux[ST_GEQ] = geq_q;
        rdMux[ST_WPE] = wpe_q;
        rdMux[ST_RPE] = rpe_q;
        rdMux[ST_CNT +: CNT_W] = count_q;
      end
      REG_INT_STAT: rdMux[INT_W-1:0] = intStat_q;
      REG_INT_EN: rdMux[INT_W-1:0] = intEn_q;
      default: rdMux = '0;
    endcase
  end

  // read data registered at the address phase
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hrdata <= '0;
    end else if (addrPhase && !hwrite) begin
      hrdata <= rdMux;
    end
  end

  // writable registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RST;
      intEn_q <= '0;
    end else if (dpWr_q) begin
      if (dpAddr_q == REG_CTRL) begin
        ctrl_q <= hwdata;
      end
      if (dpAddr_q == REG_INT_EN) begin
        intEn_q <= hwdata[INT_W-1:0];
      end
    end
  end

  // sticky status, a new event beats a clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      intStat_q <= '0;
    end else begin
      intStat_q <= (intStat_q & ~intClr) | intEv;
    end
  end

  // level interrupt
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((intStat_q & ~intClr | intEv) & intEn_q);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // threshold flags hold their reset value for the first cycle after release
  full_block_a: assert property (
    (wrReq && full && !rdDo && !ptrClr) |=> count_q == $past(count_q))
    else $error("write taken while full");
  empty_block_a: assert property (
    (rdReq && empty_q) |=> rdPtr_q == $past(rdPtr_q) || $past(ptrClr))
    else $error("read taken while empty");
  eq_level_a: assert property (
    !$past(sys_rst) && !$past(coarse) |-> eq_q == ($past(count_q) == CNT_W'($past(level))))
    else $error("equal flag wrong");
  geq_level_a: assert property (
    !$past(sys_rst) && !$past(coarse) |-> geq_q == ($past(count_q) >= CNT_W'($past(level))))
    else $error("at or above flag wrong");
  cap_bound_a: assert property (
    $stable(depthW) [*2] |-> count_q <= depthW)
    else $error("occupancy beyond capacity");
  gen_parity_a: assert property (
    (wrDo && parity_gen_en) |-> parityOk(wrWord, parity_odd_sel))
    else $error("generated parity wrong");
  rd_parity_a: assert property (
    (rdDo && !ptrClr) ##1 !ptrClr |=> rpe_q == !parityOk($past(rdWord), $past(parity_odd_sel)))
    else $error("read parity flag wrong");
  wr_parity_a: assert property (
    (wrDo && !parity_gen_en) |=> wpe_q == !parityOk($past(wrDataS), $past(parity_odd_sel)))
    else $error("write parity flag wrong");
  ptr_reset_a: assert property (
    ptrClr |=> count_q == '0 && empty_q && rd_data == '0 && wrPtr_q == '0)
    else $error("reset did not clear fifo");
  empty_fall_a: assert property (
    $changed(empty_q) |-> $past(rdFall) || $past(ptrClr))
    else $error("empty moved off the falling edge");
  coarse_eq_a: assert property (
    !$past(sys_rst) && $past(coarse) |->
      eq_q == ($past(count_q) == CNT_W'({$past(level), 1'b0}) + CNT_W'(1)))
    else $error("coarse equal flag wrong");
  wr_count_a: assert property (
    (wrDo && !rdDo) |=> count_q == $past(count_q) + CNT_W'(1))
    else $error("accepted write not counted");
endmodule // efb_fifo_top
`default_nettype wire

//--- dv/efb_user_model.sv
// user fabric model that drives the fifo write and read pins
// assumes mclk only paces it; pin clocks stand still between frames
`default_nettype none
module efb_user_model
  import efb_pkg::*;
(
  input wire logic mclk,
  output logic wr_clk,
  output logic wr_sel_n,
  output logic wr_strobe_n,
  output logic [DATA_W-1:0] wr_data,
  output logic rd_clk,
  output logic rd_sel_n,
  output logic rd_strobe_n,
  output logic fifo_rst_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle pins: clocks low, selects and strobes high
  initial begin
    wr_clk = 1'b0;
    wr_sel_n = 1'b1;
    wr_strobe_n = 1'b1;
    wr_data = '0;
    rd_clk = 1'b0;
    rd_sel_n = 1'b1;
    rd_strobe_n = 1'b1;
    fifo_rst_n = 1'b1;
  end

  // pin phases of four or more mclk keep every pin level past the synchroniser
  task automatic waitC(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // one word on its own write clock; a write only when both levels are low
  task automatic push(input logic [DATA_W-1:0] d, input logic selN, input logic stbN);
    @(posedge mclk);
    wr_data <= d;
    wr_sel_n <= selN; // select and strobe from the caller, both low to write
    wr_strobe_n <= stbN;
    waitC(4);
    wr_clk <= ~wr_clk; // rising edge from the idle low level
    waitC(4);
    wr_clk <= ~wr_clk;
    waitC(4);
    wr_sel_n <= 1'b1;
    wr_strobe_n <= 1'b1;
    wr_data <= ~d; // released data must not look valid
    waitC(4);
  endtask

  // one read clock pulse; both levels low make it a read request
  task automatic pop(input logic selN, input logic stbN);
    @(posedge mclk);
    rd_sel_n <= selN;
    rd_strobe_n <= stbN;
    waitC(4);
    rd_clk <= ~rd_clk; // rising edge from the idle low level
    waitC(4);
    rd_clk <= ~rd_clk; // falling edge lets the empty flag move
    waitC(8);
    rd_sel_n <= 1'b1;
    rd_strobe_n <= 1'b1;
    waitC(4);
  endtask

  // pointer reset pulse, active low
  task automatic rstPulse();
    @(posedge mclk);
    fifo_rst_n <= ~fifo_rst_n; // idle high, pulled low
    waitC(6);
    fifo_rst_n <= ~fifo_rst_n; // back to idle high
    waitC(6);
  endtask
endmodule // efb_user_model
`default_nettype wire

//--- dv/tb_embedded_ram_fifo_block.sv
// self-checking bench: AHB-Lite register tasks plus pin-level fifo traffic
// assumes efb_pkg compiled first; a 512-word build so the coarse level mode is reachable
`default_nettype none
module tb_embedded_ram_fifo_block
  import efb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0; // 50 MHz system clock
  logic sys_rst;
  logic hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hready; // single slave: its hreadyout is the bus ready
  logic hreadyout, hresp;
  wire logic wr_clk, wr_sel_n, wr_strobe_n, rd_clk, rd_sel_n, rd_strobe_n, fifo_rst_n; // model
  wire logic [DATA_W-1:0] wr_data; // driven by the user model
  logic [DATA_W-1:0] rd_data;
  logic full, empty, at_thresh, at_or_above_thresh, rd_parity_err, wr_parity_err, irq;
  int mismatches = 0;
  int checked = 0;

  assign hready = hreadyout;
  always #10 mclk = ~mclk;

  efb_fifo_top #(.ADDR_W(9), .DSEL_W(4)) dut (.mclk(mclk), .sys_rst(sys_rst),
    .wr_clk(wr_clk), .wr_sel_n(wr_sel_n), .wr_strobe_n(wr_strobe_n), .wr_data(wr_data),
    .rd_clk(rd_clk), .rd_sel_n(rd_sel_n), .rd_strobe_n(rd_strobe_n), .fifo_rst_n(fifo_rst_n),
    .rd_data(rd_data), .full(full), .empty(empty), .at_thresh(at_thresh),
    .at_or_above_thresh(at_or_above_thresh), .rd_parity_err(rd_parity_err),
    .wr_parity_err(wr_parity_err), .irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

  efb_user_model u_user (.mclk(mclk), .wr_clk(wr_clk), .wr_sel_n(wr_sel_n),
    .wr_strobe_n(wr_strobe_n), .wr_data(wr_data), .rd_clk(rd_clk), .rd_sel_n(rd_sel_n),
    .rd_strobe_n(rd_strobe_n), .fifo_rst_n(fifo_rst_n));

  // counts, verdict and end of run
  task automatic give_verdict();
    $display("Counts: %0d mismatches, %0d checked", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one compare, reported at once on a mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  // bounded wait for hready high at a rising edge
  task automatic waitReady();
    int n;
    n = 0;
    @(posedge mclk);
    while (hready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 20) begin
      mismatches++;
      give_verdict();
    end
  endtask

  // single word transfer: address phase, then data phase
  task automatic busAccess(input logic [31:0] a, input logic wr, input logic [31:0] wd,
                           output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2; // whole word
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
  endtask

  task automatic regWr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    busAccess(a, 1'b1, d, dummy);
  endtask

  task automatic regRd(input logic [31:0] a, output logic [31:0] d);
    busAccess(a, 1'b0, 32'h0, d);
  endtask

  // main sequence
  initial begin
    logic [31:0] r;
    logic [DATA_W-1:0] exp [4];
    logic [PAY_W-1:0] p;
    logic odd;
    logic gen;
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    // reset values and an unmapped place
    regRd(32'(REG_CTRL), r);
    chk(r, 32'h0000_0007);
    regRd(32'(REG_STATUS), r);
    chk(r, 32'h0000_000e);
    regRd(32'h0000_0014, r);
    chk(r, 32'h0);
    chk({31'h0, hresp}, 32'h0); // unmapped place still answers okay
    regWr(32'(REG_INT_EN), 32'h0000_000f);
    // four-word fifo, level two, fill past full
    regWr(32'(REG_CTRL), 32'h0000_0201);
    // select or strobe alone is no write
    u_user.push(9'h011, 1'b0, 1'b1);
    u_user.push(9'h011, 1'b1, 1'b0);
    regRd(32'(REG_STATUS), r);
    chk(32'(r[24:16]), 32'h0);
    for (int i = 0; i < 4; i++) begin
      p = 8'h35 + 8'(i * 17);
      exp[i] = {^p, p};
      u_user.push(exp[i], 1'b0, 1'b0);
      regRd(32'(REG_STATUS), r);
      chk(32'(r[24:16]), 32'(i + 1));
      chk({31'h0, at_thresh}, {31'h0, i == 1});
      chk({31'h0, at_or_above_thresh}, {31'h0, i >= 1});
      chk({31'h0, full}, {31'h0, i == 3});
    end
    u_user.push(9'h0aa, 1'b0, 1'b0);
    regRd(32'(REG_STATUS), r);
    chk(32'(r[24:16]), 32'h4);
    regRd(32'(REG_INT_STAT), r);
    chk(r & 32'h4, 32'h4);
    chk({31'h0, irq}, 32'h1);
    regWr(32'(REG_INT_CLR), 32'h0000_000f);
    regRd(32'(REG_INT_STAT), r);
    chk(r, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // half requests read nothing, then drain in order and a refused read
    u_user.pop(1'b1, 1'b1);
    u_user.pop(1'b0, 1'b1);
    u_user.pop(1'b1, 1'b0);
    regRd(32'(REG_STATUS), r);
    chk(32'(r[24:16]), 32'h4);
    chk({23'h0, rd_data}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      u_user.pop(1'b0, 1'b0);
      chk({23'h0, rd_data}, {23'h0, exp[i]});
      chk({31'h0, rd_parity_err}, 32'h0);
    end
    chk({31'h0, empty}, 32'h1);
    u_user.pop(1'b0, 1'b0);
    chk({23'h0, rd_data}, {23'h0, exp[3]});
    regRd(32'(REG_INT_STAT), r);
    chk(r & 32'h8, 32'h8);
    // every parity polarity with generation off and on, bad ninth bit in
    for (int m = 0; m < 4; m++) begin
      odd = m[0];
      gen = m[1];
      regWr(32'(REG_CTRL), {26'h0, gen, odd, 4'h1});
      regWr(32'(REG_INT_CLR), 32'h0000_000f);
      p = 8'h5c + 8'(m);
      u_user.push({~(^p ^ odd), p}, 1'b0, 1'b0);
      chk({31'h0, wr_parity_err}, {31'h0, ~gen});
      regRd(32'(REG_INT_STAT), r);
      chk(r & 32'h1, {31'h0, ~gen});
      u_user.pop(1'b1, 1'b1);
      u_user.pop(1'b0, 1'b0);
      chk({23'h0, rd_data}, {23'h0, gen ? (^p ^ odd) : ~(^p ^ odd), p});
      chk({31'h0, rd_parity_err}, {31'h0, ~gen});
    end
    // 512 words, level one: equal at three stored
    regWr(32'(REG_CTRL), 32'h0000_0108);
    for (int n = 1; n <= 3; n++) begin
      u_user.push(9'h000, 1'b0, 1'b0);
      chk({31'h0, at_thresh}, {31'h0, n == 3});
      chk({31'h0, at_or_above_thresh}, {31'h0, n >= 3});
    end
    // pointer reset pin empties the fifo
    u_user.rstPulse();
    chk({31'h0, empty}, 32'h1);
    chk({23'h0, rd_data}, 32'h0);
    regRd(32'(REG_STATUS), r);
    chk(32'(r[24:16]), 32'h0);
    // masked event: status still set, line stays low
    regWr(32'(REG_INT_EN), 32'h0);
    regWr(32'(REG_INT_CLR), 32'h0000_000f);
    u_user.pop(1'b0, 1'b0);
    regRd(32'(REG_INT_STAT), r);
    chk(r & 32'h8, 32'h8);
    chk({31'h0, irq}, 32'h0);
    give_verdict();
  end
endmodule // tb_embedded_ram_fifo_block
`default_nettype wire
